//--- design/link_opts_defs.svh
// Register map, field layout, codes and reset values of the serial link options block.
`ifndef LINK_OPTS_DEFS_SVH
`define LINK_OPTS_DEFS_SVH
// Functional notes
// - Lower mapping: lanes 0-3 of links A and B carry data, others powered down.
// - Upper mapping: lanes 4-7 of both links carry data, lanes 0-3 powered down.
// - Sync source: 0 dedicated input, 1 timestamp input, 2 software request only.
// - Format bit: 0 offset binary, 1 two's complement; resets to 1.
// - In 8b/10b modes the scrambler bit turns scrambling off or on; resets to 1.
// - In 64b/66b modes the payload is always scrambled.
// - Test pattern 0 is normal data; 1 to 6 select PRBS7 to D21.5 in order.
// - Codes 7 to 16 select the remaining patterns; 12 and 17-31 are reserved.
// - Link A sends the identifier, link B sends the identifier plus one.
// - The lowest identifier bit is forced to zero when stored.
// - Comma select: 0 K28.7, 1 K28.1, 2 K28.5, 3 reserved; 8b/10b only.
// - The comma replaces a frame's last octet only where that octet allows it.
// - Link disabled: link and multiframe counter in reset, serializers off.
// - Software sync bit at 0 requests synchronisation; at 1 releases it.

// Register byte addresses.
`define ADDR_LINK_ENABLE 10'h200
`define ADDR_SW_SYNC     10'h203
`define ADDR_CTRL        10'h204
`define ADDR_TEST        10'h205
`define ADDR_IDENT       10'h206
`define ADDR_COMMA       10'h207
`define ADDR_STATUS      10'h20F

// Field positions.
`define CTRL_SCR      0
`define CTRL_FMT      1
`define CTRL_SYNC_LO  2
`define CTRL_SYNC_HI  3
`define CTRL_UPPER    4
`define TP_MSB        4
`define COMMA_MSB     1

// Reset values.
`define RST_SW_SYNC   1'b1
`define RST_FMT       1'b1
`define RST_SCR       1'b1

// Sync source selections.
`define SYNC_DEDICATED 2'h0
`define SYNC_TSTAMP    2'h1
`define SYNC_NONE      2'h2

// Test pattern codes.
`define TP_NORMAL   5'h00
`define TP_PRBS7    5'h01
`define TP_PRBS15   5'h02
`define TP_PRBS23   5'h03
`define TP_RAMP     5'h04
`define TP_TRANS    5'h05
`define TP_D21_5    5'h06
`define TP_K28_5    5'h07
`define TP_REP_ALN  5'h08
`define TP_RPAT     5'h09
`define TP_LOW      5'h0A
`define TP_HIGH     5'h0B
`define TP_PRBS9    5'h0D
`define TP_PRBS31   5'h0E
`define TP_CLOCK    5'h0F
`define TP_K28_7    5'h10

// Comma selections and their octets.
`define COMMA_SEL_K28_7 2'h0
`define COMMA_SEL_K28_1 2'h1
`define COMMA_SEL_K28_5 2'h2
`define K28_7 8'hFC
`define K28_1 8'h3C
`define K28_5 8'hBC

// Lane masks and identifier handling.
`define LANES_LOW   8'h0F
`define LANES_HIGH  8'hF0
`define LANES_OFF   8'h00
`define IDENT_MASK  8'hFE
`define IDENT_STEP  8'h01
`endif

//--- design/link_opts_pkg.sv
// Types shared by the serial link options block.
package link_opts_pkg;
   // Test pattern kinds driven towards the lane generators.
   typedef enum logic [4:0] {
      PAT_NORMAL, PAT_PRBS7, PAT_PRBS15, PAT_PRBS23, PAT_RAMP, PAT_TRANSPORT,
      PAT_D21_5, PAT_K28_5, PAT_REPEAT_ALIGN, PAT_MOD_RPAT, PAT_HOLD_LOW,
      PAT_HOLD_HIGH, PAT_PRBS9, PAT_PRBS31, PAT_CLOCK, PAT_K28_7, PAT_RESERVED
   } pattern_kind_t;
endpackage

//--- design/frame_end_inserter.sv
// Opportunistic end-of-frame comma substitution on one octet stream.
`include "link_opts_defs.svh"
module frame_end_inserter (
   // Clock and control.
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       clk_en,
   input  wire logic       insert_on,
   input  wire logic       scramble_on,
   input  wire logic [7:0] comma_code,
   // Octet input.
   input  wire logic       in_valid,
   input  wire logic       in_frame_end,
   input  wire logic [7:0] in_data,
   // Octet output.
   output logic            out_valid,
   output logic [7:0]      out_data,
   output logic            out_is_k
);
   typedef struct packed {
      logic [7:0] prev_end;
      logic       valid;
      logic [7:0] data;
      logic       is_k;
   } ins_state_t;

   ins_state_t s_q;
   ins_state_t s_d;
   logic       match;

   // A frame-end octet is replaceable when it repeats the previous frame end
   // (plain data) or already equals the comma octet (scrambled data).
   assign match = scramble_on ? (in_data == comma_code) : (in_data == s_q.prev_end);

   // Next state: pass octets through and swap in the comma where allowed.
   always_comb begin
      s_d = s_q;
      s_d.valid = in_valid;
      if (in_valid) begin
         s_d.data = in_data;
         s_d.is_k = 1'b0;
         if (in_frame_end) begin
            s_d.prev_end = in_data;
            if (insert_on && match) begin
               s_d.data = comma_code;
               s_d.is_k = 1'b1;
            end
         end
      end
   end

   // State register with synchronous reset and clock enable.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s_q <= '0;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign out_valid = s_q.valid;
   assign out_data  = s_q.data;
   assign out_is_k  = s_q.is_k;

   // A matching frame end leaves as the comma one cycle later.
   property p_insert;
      @(posedge clock) disable iff (!rst_n)
      clk_en && in_valid && in_frame_end && insert_on && match
      |=> out_is_k && out_data == $past(comma_code);
   endproperty
   a_insert: assert property (p_insert) else $error("comma not inserted");

   // Octets that are not frame ends never become commas.
   property p_no_insert;
      @(posedge clock) disable iff (!rst_n)
      clk_en && in_valid && !in_frame_end |=> !out_is_k && out_data == $past(in_data);
   endproperty
   a_no_insert: assert property (p_no_insert) else $error("comma on mid frame");
endmodule

//--- design/serial_link_tx_options.sv
// Configuration registers and option logic of the serial output link.
//
// Added by the designer: strobed register access.
`include "link_opts_defs.svh"
module serial_link_tx_options #(
   parameter int SAMPLE_W = 12
) (
   // Clock, reset and clock enable.
   input  wire logic                     clock,
   input  wire logic                     rst_n,
   input  wire logic                     clk_en,
   // Register port.
   input  wire logic [9:0]               reg_addr,
   input  wire logic [7:0]               reg_wdata,
   input  wire logic                     reg_write,
   input  wire logic                     reg_read,
   output logic [7:0]                    reg_rdata,
   // Sync pins and mode information.
   input  wire logic                     dedicated_sync_input_n,
   input  wire logic                     timestamp_input_n,
   input  wire logic                     timestamp_receiver_enable,
   input  wire logic                     mode_uses_64b66b,
   // Sample path.
   input  wire logic [SAMPLE_W-1:0]      sample_in,
   output logic [SAMPLE_W-1:0]           sample_out,
   // Octet path.
   input  wire logic                     octet_valid,
   input  wire logic                     octet_frame_end,
   input  wire logic [7:0]               octet_data,
   output logic                          lane_valid,
   output logic [7:0]                    lane_data,
   output logic                          lane_is_k,
   // Link controls.
   output logic [7:0]                    lane_power_on_a,
   output logic [7:0]                    lane_power_on_b,
   output logic                          link_reset,
   output logic                          serializer_clock_on,
   output logic                          scramble_on,
   output logic                          sync_request,
   output link_opts_pkg::pattern_kind_t  test_pattern,
   output logic [7:0]                    ident_a,
   output logic [7:0]                    ident_b
);
   import link_opts_pkg::*;

   typedef struct packed {
      logic                link_enable;
      logic                software_sync_request_n;
      logic                upper_lane_mapping;
      logic [1:0]          sync_source;
      logic                sample_number_format;
      logic                payload_scrambler_on;
      logic [`TP_MSB:0]    lane_test_pattern_select;
      logic [7:0]          link_identifier_value;
      logic [`COMMA_MSB:0] frame_end_comma_select;
      logic                ded_s1;
      logic                ded_s2;
      logic                ts_s1;
      logic                ts_s2;
      logic                sync_req;
      logic [SAMPLE_W-1:0] sample;
      logic [7:0]          rdata;
   } opt_state_t;

   localparam opt_state_t S_RESET = '{
      software_sync_request_n : `RST_SW_SYNC,
      sync_source             : `SYNC_DEDICATED,
      sample_number_format    : `RST_FMT,
      payload_scrambler_on    : `RST_SCR,
      lane_test_pattern_select: `TP_NORMAL,
      frame_end_comma_select  : `COMMA_SEL_K28_7,
      ded_s1                  : 1'b1,
      ded_s2                  : 1'b1,
      ts_s1                   : 1'b1,
      ts_s2                   : 1'b1,
      default                 : '0
   };

   opt_state_t s_q;
   opt_state_t s_d;
   logic [7:0] comma_code;
   logic       insert_on;
   logic       sync_req_d;

   // Maps a test pattern code onto the pattern kind.
   function automatic pattern_kind_t decode_pattern(input logic [`TP_MSB:0] code);
      case (code)
         `TP_NORMAL:  decode_pattern = PAT_NORMAL;
         `TP_PRBS7:   decode_pattern = PAT_PRBS7;
         `TP_PRBS15:  decode_pattern = PAT_PRBS15;
         `TP_PRBS23:  decode_pattern = PAT_PRBS23;
         `TP_RAMP:    decode_pattern = PAT_RAMP;
         `TP_TRANS:   decode_pattern = PAT_TRANSPORT;
         `TP_D21_5:   decode_pattern = PAT_D21_5;
         `TP_K28_5:   decode_pattern = PAT_K28_5;
         `TP_REP_ALN: decode_pattern = PAT_REPEAT_ALIGN;
         `TP_RPAT:    decode_pattern = PAT_MOD_RPAT;
         `TP_LOW:     decode_pattern = PAT_HOLD_LOW;
         `TP_HIGH:    decode_pattern = PAT_HOLD_HIGH;
         `TP_PRBS9:   decode_pattern = PAT_PRBS9;
         `TP_PRBS31:  decode_pattern = PAT_PRBS31;
         `TP_CLOCK:   decode_pattern = PAT_CLOCK;
         `TP_K28_7:   decode_pattern = PAT_K28_7;
         default:     decode_pattern = PAT_RESERVED;
      endcase
   endfunction

   // Maps a comma selection onto its octet; the reserved value falls back to K28.7.
   function automatic logic [7:0] comma_octet(input logic [`COMMA_MSB:0] sel);
      if (sel == `COMMA_SEL_K28_1) begin
         comma_octet = `K28_1;
      end else if (sel == `COMMA_SEL_K28_5) begin
         comma_octet = `K28_5;
      end else begin
         comma_octet = `K28_7;
      end
   endfunction

   // Request from the selected pin or from software; pins are active low.
   always_comb begin
      sync_req_d = !s_q.software_sync_request_n;
      if (s_q.sync_source == `SYNC_DEDICATED) begin
         sync_req_d = sync_req_d || !s_q.ded_s2;
      end else if (s_q.sync_source == `SYNC_TSTAMP) begin
         sync_req_d = sync_req_d || (timestamp_receiver_enable && !s_q.ts_s2);
      end
   end

   // Next state: register writes, read data, pin synchronisers and sample format.
   always_comb begin
      s_d = s_q;
      s_d.ded_s1 = dedicated_sync_input_n;
      s_d.ded_s2 = s_q.ded_s1;
      s_d.ts_s1 = timestamp_input_n;
      s_d.ts_s2 = s_q.ts_s1;
      s_d.sync_req = sync_req_d;
      s_d.rdata = '0;
      if (s_q.sample_number_format) begin
         s_d.sample = sample_in;
      end else begin
         s_d.sample = {~sample_in[SAMPLE_W-1], sample_in[SAMPLE_W-2:0]};
      end
      if (reg_write) begin
         if (reg_addr == `ADDR_LINK_ENABLE) begin
            s_d.link_enable = reg_wdata[0];
         end else if (reg_addr == `ADDR_SW_SYNC) begin
            s_d.software_sync_request_n = reg_wdata[0];
         end else if (reg_addr == `ADDR_CTRL) begin
            s_d.upper_lane_mapping = reg_wdata[`CTRL_UPPER];
            s_d.sync_source = reg_wdata[`CTRL_SYNC_HI:`CTRL_SYNC_LO];
            s_d.sample_number_format = reg_wdata[`CTRL_FMT];
            s_d.payload_scrambler_on = reg_wdata[`CTRL_SCR];
         end else if (reg_addr == `ADDR_TEST) begin
            s_d.lane_test_pattern_select = reg_wdata[`TP_MSB:0];
         end else if (reg_addr == `ADDR_IDENT) begin
            s_d.link_identifier_value = reg_wdata & `IDENT_MASK;
         end else if (reg_addr == `ADDR_COMMA) begin
            s_d.frame_end_comma_select = reg_wdata[`COMMA_MSB:0];
         end
      end
      if (reg_read) begin
         if (reg_addr == `ADDR_LINK_ENABLE) begin
            s_d.rdata = {7'h00, s_q.link_enable};
         end else if (reg_addr == `ADDR_SW_SYNC) begin
            s_d.rdata = {7'h00, s_q.software_sync_request_n};
         end else if (reg_addr == `ADDR_CTRL) begin
            s_d.rdata = {3'h0, s_q.upper_lane_mapping, s_q.sync_source,
                         s_q.sample_number_format, s_q.payload_scrambler_on};
         end else if (reg_addr == `ADDR_TEST) begin
            s_d.rdata = {3'h0, s_q.lane_test_pattern_select};
         end else if (reg_addr == `ADDR_IDENT) begin
            s_d.rdata = s_q.link_identifier_value;
         end else if (reg_addr == `ADDR_COMMA) begin
            s_d.rdata = {6'h00, s_q.frame_end_comma_select};
         end else if (reg_addr == `ADDR_STATUS) begin
            s_d.rdata = {3'h0, mode_uses_64b66b, s_q.ts_s2, s_q.ded_s2,
                         !s_q.link_enable, s_q.sync_req};
         end
      end
   end

   // State register with synchronous reset; a low clock enable freezes it.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s_q <= S_RESET;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // Lane power follows the mapping and is all off while the link is disabled.
   always_comb begin
      if (!s_q.link_enable) begin
         lane_power_on_a = `LANES_OFF;
      end else if (s_q.upper_lane_mapping) begin
         lane_power_on_a = `LANES_HIGH;
      end else begin
         lane_power_on_a = `LANES_LOW;
      end
   end
   assign lane_power_on_b = lane_power_on_a;

   // Link hold, serializer clock gate and scrambling.
   assign link_reset          = !s_q.link_enable;
   assign serializer_clock_on = s_q.link_enable;
   assign scramble_on         = mode_uses_64b66b || s_q.payload_scrambler_on;

   // Option values towards the link logic.
   assign sync_request = s_q.sync_req;
   assign test_pattern = decode_pattern(s_q.lane_test_pattern_select);
   assign ident_a      = s_q.link_identifier_value;
   assign ident_b      = s_q.link_identifier_value + `IDENT_STEP;
   assign sample_out   = s_q.sample;
   assign reg_rdata    = s_q.rdata;

   // Commas go in only on running 8b/10b links sending normal data.
   assign comma_code = comma_octet(s_q.frame_end_comma_select);
   assign insert_on  = s_q.link_enable && !mode_uses_64b66b && test_pattern == PAT_NORMAL;

   // End-of-frame comma substitution on the octet stream.
   frame_end_inserter u_frame_end (
      .clock       (clock),
      .rst_n       (rst_n),
      .clk_en      (clk_en),
      .insert_on   (insert_on),
      .scramble_on (scramble_on),
      .comma_code  (comma_code),
      .in_valid    (octet_valid),
      .in_frame_end(octet_frame_end),
      .in_data     (octet_data),
      .out_valid   (lane_valid),
      .out_data    (lane_data),
      .out_is_k    (lane_is_k)
   );

   // A control write with the enable set steers the lane map on the next cycle.
   sequence s_ctrl_write(logic upper);
      clk_en && reg_write && reg_addr == `ADDR_CTRL && reg_wdata[`CTRL_UPPER] == upper
      && s_q.link_enable;
   endsequence

   property p_lane_low;
      @(posedge clock) disable iff (!rst_n)
      s_ctrl_write(1'b0) |=> lane_power_on_a == `LANES_LOW && lane_power_on_b == `LANES_LOW;
   endproperty
   a_lane_low: assert property (p_lane_low) else $error("lower map wrong");

   property p_lane_high;
      @(posedge clock) disable iff (!rst_n)
      s_ctrl_write(1'b1) |=> lane_power_on_a == `LANES_HIGH && lane_power_on_b == `LANES_HIGH;
   endproperty
   a_lane_high: assert property (p_lane_high) else $error("upper map wrong");

   // Disabling the link powers all lanes down and holds the link in reset.
   property p_disable;
      @(posedge clock) disable iff (!rst_n)
      clk_en && reg_write && reg_addr == `ADDR_LINK_ENABLE && !reg_wdata[0]
      |=> link_reset && !serializer_clock_on && lane_power_on_a == `LANES_OFF;
   endproperty
   a_disable: assert property (p_disable) else $error("link not held");

   // A software request reaches the sync output two enabled cycles later.
   sequence s_sw_request;
      clk_en && reg_write && reg_addr == `ADDR_SW_SYNC && !reg_wdata[0] ##1 clk_en;
   endsequence

   property p_sw_sync;
      @(posedge clock) disable iff (!rst_n)
      s_sw_request |=> sync_request;
   endproperty
   a_sw_sync: assert property (p_sw_sync) else $error("software sync lost");

   // With no pin selected and software released, no request is raised.
   property p_no_pin;
      @(posedge clock) disable iff (!rst_n)
      clk_en && s_q.sync_source == `SYNC_NONE && s_q.software_sync_request_n
      |=> !sync_request;
   endproperty
   a_no_pin: assert property (p_no_pin) else $error("pin used while ignored");

   property p_ded_pin;
      @(posedge clock) disable iff (!rst_n)
      clk_en && s_q.sync_source == `SYNC_DEDICATED && !s_q.ded_s2 |=> sync_request;
   endproperty
   a_ded_pin: assert property (p_ded_pin) else $error("dedicated sync lost");

   // Offset binary flips the sign bit of the captured sample.
   property p_offset_bin;
      @(posedge clock) disable iff (!rst_n)
      clk_en && !s_q.sample_number_format
      |=> sample_out[SAMPLE_W-1] != $past(sample_in[SAMPLE_W-1]);
   endproperty
   a_offset_bin: assert property (p_offset_bin) else $error("format not applied");

   // Scrambling follows the bit in 8b/10b modes and is forced in 64b/66b modes.
   property p_scramble;
      @(posedge clock) disable iff (!rst_n)
      scramble_on == (mode_uses_64b66b || s_q.payload_scrambler_on);
   endproperty
   a_scramble: assert property (p_scramble) else $error("scrambling wrong");

   // A stored identifier is even and link B carries it plus one.
   property p_ident;
      @(posedge clock) disable iff (!rst_n)
      clk_en && reg_write && reg_addr == `ADDR_IDENT
      |=> ident_a == ($past(reg_wdata) & `IDENT_MASK) && ident_b == ident_a + `IDENT_STEP;
   endproperty
   a_ident: assert property (p_ident) else $error("identifier wrong");

   // Writing the PRBS9 pattern code selects the PRBS9 pattern kind.
   property p_pattern;
      @(posedge clock) disable iff (!rst_n)
      clk_en && reg_write && reg_addr == `ADDR_TEST && reg_wdata[`TP_MSB:0] == `TP_PRBS9
      |=> test_pattern == PAT_PRBS9;
   endproperty
   a_pattern: assert property (p_pattern) else $error("pattern decode wrong");

   property p_comma;
      @(posedge clock) disable iff (!rst_n)
      s_q.frame_end_comma_select == `COMMA_SEL_K28_1 |-> comma_code == `K28_1;
   endproperty
   a_comma: assert property (p_comma) else $error("comma select wrong");
endmodule

//--- tb/link_rx_model.sv
// Behavioural far-end receiver: raises sync on its pins and counts received commas.
module link_rx_model (
   // Clock.
   input  wire logic       clock,
   // Lane from the transmitter.
   input  wire logic       lane_valid,
   input  wire logic [7:0] lane_data,
   input  wire logic       lane_is_k,
   // Sync wishes from the bench.
   input  wire logic       want_sync,
   input  wire logic       want_ts,
   // Sync pins, active low, idle high.
   output logic            dedicated_sync_input_n,
   output logic            timestamp_input_n,
   output logic [7:0]      comma_cnt
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pins start idle so no request is seen out of reset.
   initial begin
      dedicated_sync_input_n = 1'b1;
      timestamp_input_n = 1'b1;
      comma_cnt = 8'h00;
   end
   // Pins follow the wishes one edge later; each K octet other than 00 is counted.
   always @(posedge clock) begin
      dedicated_sync_input_n <= !want_sync;
      timestamp_input_n <= !want_ts;
      if (lane_valid && lane_is_k && lane_data != 8'h00) comma_cnt <= comma_cnt + 8'h01;
   end
endmodule

//--- tb/tb.sv
// Self-checking bench for the serial link options block.
`define CHK(g, e) check(32'(g), 32'(e))
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import link_opts_pkg::*;
   logic          clock, rst_n, reg_write, reg_read, want_sync, want_ts, lane_valid, lane_is_k;
   logic          timestamp_receiver_enable, mode_uses_64b66b, octet_valid, octet_frame_end;
   logic          link_reset, serializer_clock_on, scramble_on, sync_request, clk_en;
   logic          dedicated_sync_input_n, timestamp_input_n;
   logic [9:0]    reg_addr;
   logic [7:0]    reg_wdata, reg_rdata, octet_data, lane_data, ident_a, ident_b, comma_cnt;
   logic [7:0]    lane_power_on_a, lane_power_on_b;
   logic [11:0]   sample_in, sample_out;
   pattern_kind_t test_pattern;
   int            error_cnt, checks_done, i;
   // Clock of 100 ns period.
   always #50 clock = ~clock;
   serial_link_tx_options uut (.clock, .rst_n, .clk_en, .reg_addr, .reg_wdata,
      .reg_write, .reg_read, .reg_rdata, .dedicated_sync_input_n, .timestamp_input_n,
      .timestamp_receiver_enable, .mode_uses_64b66b, .sample_in, .sample_out, .octet_valid,
      .octet_frame_end, .octet_data, .lane_valid, .lane_data, .lane_is_k, .lane_power_on_a,
      .lane_power_on_b, .link_reset, .serializer_clock_on, .scramble_on, .sync_request,
      .test_pattern, .ident_a, .ident_b);
   link_rx_model rx (.clock, .lane_valid, .lane_data, .lane_is_k, .want_sync, .want_ts,
      .dedicated_sync_input_n, .timestamp_input_n, .comma_cnt);
   // Prints the counts and the verdict, then stops.
   task automatic close_out;
      $display("mismatches %0d, comparisons %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Compares with case equality so unknowns never match.
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // One-cycle register write.
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
      #1;
   endtask
   // One-cycle register read; data are looked at in the following cycle only.
   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 `CHK(reg_rdata, e);
   endtask
   // Waits a bounded time for the sync request to reach a level.
   task automatic sync_is(input logic e);
      for (i = 0; i < 8 && sync_request !== e; i++) begin
         @(posedge clock);
         #1;
      end
      `CHK(sync_request, e);
      if (sync_request !== e) close_out();
   endtask
   // Sends one octet and compares the lane one cycle later.
   task automatic oct(input logic f, input logic [7:0] d, input logic [7:0] x, input logic k);
      @(posedge clock);
      octet_valid <= 1'b1;
      octet_frame_end <= f;
      octet_data <= d;
      @(posedge clock);
      octet_valid <= 1'b0;
      #1 `CHK({lane_valid, lane_is_k, lane_data}, {1'b1, k, x});
   endtask
   // Expected pattern kind of a test code; 12 and above 16 are reserved.
   function automatic pattern_kind_t pexp(input int c);
      if (c == 12 || c > 16) return PAT_RESERVED;
      return pattern_kind_t'(c < 12 ? c : c - 1);
   endfunction
   // Main sequence.
   initial begin
      {clock, rst_n, reg_write, reg_read, want_sync, want_ts, octet_valid} = 7'h00;
      {clk_en, timestamp_receiver_enable, mode_uses_64b66b, octet_frame_end} = 4'h8;
      {reg_addr, reg_wdata, octet_data} = 26'h0;
      sample_in = 12'h800;
      repeat (5) @(posedge clock);
      #1 `CHK({link_reset, serializer_clock_on, lane_power_on_a, lane_power_on_b}, 18'h20000);
      @(posedge clock);
      rst_n <= 1'b1;
      rd(10'h204, 8'h03);
      rd(10'h205, 8'h00);
      rd(10'h206, 8'h00);
      rd(10'h207, 8'h00);
      rd(10'h203, 8'h01);
      rd(10'h20F, 8'h0E);
      rd(10'h3FF, 8'h00);
      `CHK({sample_out, scramble_on}, 13'h1001);
      wr(10'h204, 8'h00);
      @(posedge clock);
      #1 `CHK({sample_out, scramble_on}, 13'h0000);
      @(posedge clock);
      mode_uses_64b66b <= 1'b1;
      #1 `CHK(scramble_on, 1'b1);
      @(posedge clock);
      mode_uses_64b66b <= 1'b0;
      wr(10'h200, 8'h01);
      `CHK({link_reset, serializer_clock_on, lane_power_on_a, lane_power_on_b}, 18'h10F0F);
      wr(10'h200, 8'h00);
      wr(10'h204, 8'h10);
      wr(10'h200, 8'h01);
      `CHK({lane_power_on_a, lane_power_on_b}, 16'hF0F0);
      wr(10'h200, 8'h00);
      `CHK({lane_power_on_a, lane_power_on_b, link_reset}, 17'h00001);
      wr(10'h206, 8'h07);
      rd(10'h206, 8'h06);
      `CHK({ident_a, ident_b}, 16'h0607);
      wr(10'h206, 8'hFF);
      `CHK({ident_a, ident_b}, 16'hFEFF);
      // A write while the clock enable is low must leave the identifier alone.
      @(posedge clock);
      clk_en <= 1'b0;
      wr(10'h206, 8'h10);
      @(posedge clock);
      clk_en <= 1'b1;
      #1 `CHK({ident_a, ident_b}, 16'hFEFF);
      want_sync <= 1'b1;
      sync_is(1'b1);
      want_sync <= 1'b0;
      sync_is(1'b0);
      wr(10'h204, 8'h14);
      timestamp_receiver_enable <= 1'b1;
      want_ts <= 1'b1;
      sync_is(1'b1);
      want_ts <= 1'b0;
      sync_is(1'b0);
      wr(10'h204, 8'h18);
      {want_sync, want_ts} <= 2'b11;
      repeat (6) @(posedge clock);
      #1 `CHK(sync_request, 1'b0);
      wr(10'h203, 8'h00);
      sync_is(1'b1);
      wr(10'h203, 8'h01);
      sync_is(1'b0);
      {want_sync, want_ts} <= 2'b00;
      // Every test code, link disabled and 8b/10b mode.
      for (int c = 0; c < 32; c++) begin
         wr(10'h205, 8'(c | 32'hE0));
         `CHK(test_pattern, pexp(c));
      end
      rd(10'h205, 8'h1F);
      wr(10'h205, 8'h00);
      wr(10'h204, 8'h02);
      // Each comma select, unscrambled: only a repeated frame end is replaced.
      for (int s = 0; s < 4; s++) begin
         wr(10'h200, 8'h00);
         wr(10'h207, 8'(s));
         rd(10'h207, 8'(s));
         wr(10'h200, 8'h01);
         oct(1'b1, 8'(8'hA0 + s), 8'(8'hA0 + s), 1'b0);
         oct(1'b1, 8'(8'hA0 + s), s == 1 ? 8'h3C : s == 2 ? 8'hBC : 8'hFC, 1'b1);
         oct(1'b0, 8'(8'hA0 + s), 8'(8'hA0 + s), 1'b0);
      end
      wr(10'h200, 8'h00);
      wr(10'h207, 8'h00);
      wr(10'h204, 8'h03);
      wr(10'h200, 8'h01);
      oct(1'b1, 8'hFC, 8'hFC, 1'b1);
      oct(1'b1, 8'h55, 8'h55, 1'b0);
      `CHK(comma_cnt, 8'h05);
      // Lane map changes on a running link; the scrambler bit stays at 1.
      wr(10'h204, 8'h13);
      `CHK({lane_power_on_a, lane_power_on_b}, 16'hF0F0);
      wr(10'h204, 8'h03);
      `CHK({lane_power_on_a, lane_power_on_b}, 16'h0F0F);
      close_out();
   end
endmodule
